// ### brownout_reset_sequencer.sv
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module brownout_reset_sequencer
  import reset_seq_pkg::*;
#(
  parameter int POWER_UP_TIMER_COUNT = POWER_UP_TIMER_CYCLES,
  parameter int POR_COUNT  = 16
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // configuration words
  input  wire logic [7:0]  power_on_config_word,
  input  wire logic        deep_sleep_bor_enable,
  input  wire logic [2:0]  initial_osc_select,
  input  wire logic        clock_fail_monitor_en,
  input  wire logic        use_crystal,
  // analog and clock status pins
  input  wire logic        supply_below_thr_pin,
  input  wire logic        supply_below_por_pin,
  input  wire logic        osc_tick_pin,
  input  wire logic        pll_lock_pin,
  input  wire logic        pll_used,
  // power mode from cpu
  input  wire logic        in_sleep,
  input  wire logic        in_deep_sleep,
  input  wire logic        deep_sleep_exit,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // outputs
  output logic             system_reset_out,
  output logic             cpu_run,
  output logic [1:0]       brownout_threshold_select,
  output logic             bor_detect_enable,
  output logic             fast_internal_rc_osc,
  output logic             trap_handler,
  output logic             por_rearm
);

  // refuse counts that leave a state with no dwell time
  if (POWER_UP_TIMER_COUNT < 1 || POR_COUNT < 1) begin : g_count_check
    $error("brownout_reset_sequencer counts must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] thr_sync_reg;
  logic [1:0] por_sync_reg;
  logic [1:0] tick_sync_reg;
  logic [1:0] lock_sync_reg;
  logic       tick_prev_reg;

  // two flops on each asynchronous pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      thr_sync_reg  <= 2'h0;
      por_sync_reg  <= 2'h0;
      tick_sync_reg <= 2'h0;
      lock_sync_reg <= 2'h0;
      tick_prev_reg <= 1'b0;
    end else begin
      thr_sync_reg  <= {thr_sync_reg[0], supply_below_thr_pin};
      por_sync_reg  <= {por_sync_reg[0], supply_below_por_pin};
      tick_sync_reg <= {tick_sync_reg[0], osc_tick_pin};
      lock_sync_reg <= {lock_sync_reg[0], pll_lock_pin};
      tick_prev_reg <= tick_sync_reg[1];
    end
  end

  // synchronised levels and the oscillator edge seen on this clock
  logic below_thr;
  logic below_por;
  logic osc_tick;
  logic pll_locked;

  assign below_thr  = thr_sync_reg[1];
  assign below_por  = por_sync_reg[1];
  assign osc_tick   = tick_sync_reg[1] & ~tick_prev_reg;
  assign pll_locked = lock_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // brown-out enable decode

  logic [1:0] bor_mode;
  logic       power_up_timer_enable;
  logic       sw_brownout_enable_reg;

  assign bor_mode    = power_on_config_word[CFG_MODE_LSB +: 2];
  assign power_up_timer_enable = power_on_config_word[CFG_POWER_UP_TIMER_BIT];
  // threshold straight from configuration, no software path
  assign brownout_threshold_select =
    power_on_config_word[CFG_THR_LSB +: 2];

  // detection enable per mode
  always_comb begin
    unique case (bor_mode)
      BOR_MODE_OFF:   bor_detect_enable = 1'b0;
      BOR_MODE_SW:    bor_detect_enable = sw_brownout_enable_reg;
      BOR_MODE_NOSLP: bor_detect_enable = ~in_sleep;
      BOR_MODE_ON:    bor_detect_enable = 1'b1;
    endcase
  end

  // deep sleep re-arms the power-on detector
  assign por_rearm = in_deep_sleep & deep_sleep_bor_enable;

  logic bor_event;
  logic por_event;

  assign bor_event = bor_detect_enable & below_thr;
  // in deep sleep only an armed detector may restart the chip
  assign por_event = below_por & (~in_deep_sleep | deep_sleep_bor_enable);

  ////////////////////////////////////////////////////////////////////////////
  // reset sequence

  // clock status, read by the sequence before the timer section
  logic        osc_ready;
  logic        clk_valid;
  seq_state_t state_reg;
  logic [31:0] cnt_reg;
  logic        is_por_reg;

  // power-on, brown-out hold, power-up timer, clock wait, run
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= ST_POR;
      cnt_reg    <= 32'h0;
      is_por_reg <= 1'b1;
    end else if (por_event) begin
      state_reg  <= ST_POR;
      cnt_reg    <= 32'h0;
      is_por_reg <= 1'b1;
    end else begin
      unique case (state_reg)
        ST_POR: begin
          if (cnt_reg >= 32'(POR_COUNT - 1)) begin
            state_reg <= below_thr && bor_detect_enable ? ST_BOR : ST_POWER_UP_TIMER;
            cnt_reg   <= 32'h0;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        ST_BOR: begin
          cnt_reg <= 32'h0;
          if (!bor_event) begin
            state_reg <= ST_POWER_UP_TIMER;
          end
        end
        ST_POWER_UP_TIMER: begin
          if (bor_event) begin
            state_reg  <= ST_BOR;
            cnt_reg    <= 32'h0;
            is_por_reg <= 1'b0;
          end else if (!power_up_timer_enable ||
                       cnt_reg >= 32'(POWER_UP_TIMER_COUNT - 1)) begin
            state_reg <= ST_CLKW;
            cnt_reg   <= 32'h0;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        ST_CLKW, ST_RUN: begin
          if (bor_event) begin
            state_reg  <= ST_BOR;
            is_por_reg <= 1'b0;
          end else if (state_reg == ST_CLKW &&
                       (clk_valid || fast_internal_rc_osc)) begin
            // the rc fallback is a valid clock once the monitor switched
            state_reg <= ST_RUN;
          end
        end
        default: state_reg <= ST_POR;
      endcase
    end
  end

  // reset output drops after the timer; clocks may still be pending then
  logic in_reset;
  assign in_reset = (state_reg == ST_POR) || (state_reg == ST_BOR) ||
                    (state_reg == ST_POWER_UP_TIMER);
  assign system_reset_out = in_reset;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator start-up, runs beside the reset delay

  // restarted only by power-on; a brown-out leaves the crystal running

  osc_startup_timer #(
    .WIDTH     (OST_WIDTH)
  ) u_ost (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .restart   (por_event),
    .osc_tick  (osc_tick),
    .osc_ready (osc_ready)
  );

  // crystal needs the start-up timer, pll needs lock; both are optional
  assign clk_valid = (~use_crystal | osc_ready) & (~pll_used | pll_locked);
  assign cpu_run   = (state_reg == ST_RUN) &&
                     (clk_valid || fast_internal_rc_osc);

  ////////////////////////////////////////////////////////////////////////////
  // clock fail monitor at reset release

  logic rst_prev_reg;
  logic frc_reg;
  logic trap_reg;

  // check the clock on the falling edge of the system reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_prev_reg <= 1'b1;
      frc_reg      <= 1'b0;
      trap_reg     <= 1'b0;
    end else begin
      rst_prev_reg <= in_reset;
      trap_reg     <= 1'b0;
      if (in_reset) begin
        frc_reg <= 1'b0;
      end else if (rst_prev_reg && clock_fail_monitor_en && !clk_valid) begin
        frc_reg  <= 1'b1;
        trap_reg <= 1'b1;
      end
    end
  end

  assign fast_internal_rc_osc = frc_reg;
  assign trap_handler         = trap_reg;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [15:0] reset_control_reg;
  logic [2:0]  osc_control_reg;
  logic [15:0] rtc_calibration_reg;
  logic [15:0] nvm_control_reg;
  logic        wr_stb;
  logic        ack_reg;

  // a write lands at the edge where the master sees ack high
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;

  // byte lanes into a 16-bit register, upper half of the bus unused
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    logic [15:0] r;
    r = old_v;
    if (sel[0]) r[7:0]  = dat[7:0];
    if (sel[1]) r[15:8] = dat[15:8];
    return r;
  endfunction : merge16

  // reset control flags; hardware set beats software clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reset_control_reg <= RESET_CONTROL_REG_POR_VAL;
    end else begin
      if (wr_stb && wb_adr_i == ADR_RESET_CONTROL_REG) begin
        reset_control_reg <= merge16(reset_control_reg, wb_dat_i, wb_sel_i);
      end
      if (state_reg == ST_POR) begin
        reset_control_reg <= RESET_CONTROL_REG_POR_VAL;
      end else if (state_reg == ST_BOR) begin
        reset_control_reg[RC_BOR] <= 1'b1;
      end
      if (deep_sleep_exit) begin
        reset_control_reg[RC_POR]   <= 1'b1;
        reset_control_reg[RC_BOR]   <= 1'b1;
        reset_control_reg[RC_DPSLP] <= 1'b1;
      end
    end
  end

  // software brown-out enable lives only in mode 01
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sw_brownout_enable_reg <= 1'b1;
    end else if (bor_mode != BOR_MODE_SW) begin
      sw_brownout_enable_reg <= 1'b0;
    end else if (wr_stb && wb_adr_i == ADR_RESET_CONTROL_REG && wb_sel_i[1]) begin
      sw_brownout_enable_reg <= wb_dat_i[RC_SW_BROWNOUT_ENABLE];
    end
  end

  // oscillator select: initial select after por/bor, kept otherwise
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc_control_reg <= OSC_FRC;
    end else if (state_reg == ST_POR || state_reg == ST_BOR) begin
      osc_control_reg <= initial_osc_select;
    end else if (wr_stb && wb_adr_i == ADR_OSC && wb_sel_i[0]) begin
      osc_control_reg <= wb_dat_i[2:0];
    end
  end

  // cleared by power-on only, survive brown-out
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rtc_calibration_reg <= RTCCAL_RST;
      nvm_control_reg     <= NVM_RST;
    end else if (state_reg == ST_POR) begin
      rtc_calibration_reg <= RTCCAL_RST;
      nvm_control_reg     <= NVM_RST;
    end else if (wr_stb) begin
      if (wb_adr_i == ADR_RTCCAL) begin
        rtc_calibration_reg <= merge16(rtc_calibration_reg, wb_dat_i,
                                       wb_sel_i);
      end
      if (wb_adr_i == ADR_NVM) begin
        nvm_control_reg <= merge16(nvm_control_reg, wb_dat_i, wb_sel_i);
      end
    end
  end

  // wishbone ack one cycle after strobe, read data registered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg  <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
      unique case (wb_adr_i)
        ADR_RESET_CONTROL_REG: begin
          wb_dat_o <= {16'h0, reset_control_reg};
          wb_dat_o[RC_SW_BROWNOUT_ENABLE] <= sw_brownout_enable_reg;
        end
        ADR_OSC:    wb_dat_o <= {29'h0, osc_control_reg};
        ADR_RTCCAL: wb_dat_o <= {16'h0, rtc_calibration_reg};
        ADR_NVM:    wb_dat_o <= {16'h0, nvm_control_reg};
        default:    wb_dat_o <= 32'h0;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;

endmodule : brownout_reset_sequencer

// ### reset_seq_pkg.sv
package reset_seq_pkg;

  localparam logic [1:0] BOR_MODE_OFF   = 2'h0;
  localparam logic [1:0] BOR_MODE_SW    = 2'h1;
  localparam logic [1:0] BOR_MODE_NOSLP = 2'h2;
  localparam logic [1:0] BOR_MODE_ON    = 2'h3;

  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_THR_LSB  = 5;
  localparam int CFG_POWER_UP_TIMER_BIT = 7;

  localparam int RC_POR    = 0;
  localparam int RC_BOR    = 1;
  localparam int RC_DPSLP  = 10;
  localparam int RC_SW_BROWNOUT_ENABLE = 13;

  localparam logic [3:0] ADR_RESET_CONTROL_REG   = 4'h0;
  localparam logic [3:0] ADR_OSC    = 4'h4;
  localparam logic [3:0] ADR_RTCCAL = 4'h8;
  localparam logic [3:0] ADR_NVM    = 4'hc;

  localparam logic [15:0] RESET_CONTROL_REG_POR_VAL = 16'h0003;
  localparam logic [2:0]  OSC_FRC      = 3'h0;
  localparam logic [15:0] RTCCAL_RST   = 16'h0000;
  localparam logic [15:0] NVM_RST      = 16'h0000;

  localparam int CLK_HZ        = 25000000;
  localparam int POWER_UP_TIMER_MS       = 64;
  localparam int POWER_UP_TIMER_CYCLES   = (CLK_HZ / 1000) * POWER_UP_TIMER_MS;
  localparam int OST_PERIODS   = 1024;
  localparam int OST_WIDTH     = 10;

  typedef enum logic [2:0] {
    ST_POR   = 3'h0,
    ST_BOR   = 3'h1,
    ST_POWER_UP_TIMER  = 3'h2,
    ST_CLKW  = 3'h3,
    ST_RUN   = 3'h4
  } seq_state_t;

endpackage : reset_seq_pkg

// ### osc_startup_timer.sv
`timescale 1ns/1ps
module osc_startup_timer
  import reset_seq_pkg::*;
#(
  parameter int WIDTH = OST_WIDTH
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic restart,
  input  wire logic osc_tick,
  output logic      osc_ready
);

  if (WIDTH < 1 || (1 << WIDTH) != OST_PERIODS) begin : g_width_check
    $error("osc_startup_timer width must cover the start-up periods");
  end

  logic [WIDTH-1:0] cnt_reg;
  logic             osc_ready_reg;

  // count oscillator periods, release after a full wrap
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg       <= '0;
      osc_ready_reg <= 1'b0;
    end else if (restart) begin
      cnt_reg       <= '0;
      osc_ready_reg <= 1'b0;
    end else if (osc_tick && !osc_ready_reg) begin
      cnt_reg <= cnt_reg + 1'b1;
      if (&cnt_reg) begin
        osc_ready_reg <= 1'b1;
      end
    end
  end

  assign osc_ready = osc_ready_reg;

endmodule : osc_startup_timer

// ### brownout_reset_sequencer_properties.sv
`timescale 1ns/1ps
module brownout_reset_sequencer_properties (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] power_on_config_word,
  input wire logic       deep_sleep_bor_enable,
  input wire logic       in_sleep,
  input wire logic       in_deep_sleep,
  input wire logic       supply_below_thr_pin,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       system_reset_out,
  input wire logic       cpu_run,
  input wire logic [1:0] brownout_threshold_select,
  input wire logic       bor_detect_enable,
  input wire logic       fast_internal_rc_osc,
  input wire logic       trap_handler,
  input wire logic       por_rearm
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire [1:0] mode = power_on_config_word[1:0];
  ////////////////////////////////////////
  chk_thr_cfg:
    assert property (brownout_threshold_select == power_on_config_word[6:5])
    else $error("threshold not from config");
  chk_mode_off:
    assert property (mode == 2'h0 |-> !bor_detect_enable)
    else $error("detect on in off mode");
  chk_mode_on:
    assert property (mode == 2'h3 |-> bor_detect_enable)
    else $error("detect off in always mode");
  chk_sleep_off:
    assert property (mode == 2'h2 |-> bor_detect_enable == !in_sleep)
    else $error("sleep gating wrong");
  chk_trip_reset:
    assert property ((bor_detect_enable && supply_below_thr_pin) [*3]
      |=> system_reset_out)
    else $error("low supply did not reset");
  chk_run_gate:
    assert property (system_reset_out |-> !cpu_run)
    else $error("run during reset");
  chk_trap_rc:
    assert property (trap_handler |-> ##[0:1]
      (fast_internal_rc_osc && !system_reset_out))
    else $error("trap without rc switch");
  chk_trap_pulse:
    assert property (trap_handler |=> !trap_handler)
    else $error("trap longer than one cycle");
  chk_rearm_eq:
    assert property (por_rearm == (in_deep_sleep && deep_sleep_bor_enable))
    else $error("rearm wrong");
  chk_ack_next:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  cover property ($fell(system_reset_out));
  cover property (trap_handler);
  cover property (mode == 2'h2 && in_sleep);
  cover property (por_rearm);
endmodule : brownout_reset_sequencer_properties

bind brownout_reset_sequencer brownout_reset_sequencer_properties u_props (
  .mclk, .rst_n, .power_on_config_word, .deep_sleep_bor_enable, .in_sleep,
  .in_deep_sleep, .supply_below_thr_pin, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .system_reset_out, .cpu_run, .brownout_threshold_select,
  .bor_detect_enable, .fast_internal_rc_osc, .trap_handler, .por_rearm
);

// ### brownout_reset_sequencer_tb.sv
`timescale 1ns/1ps
module brownout_reset_sequencer_tb;
  import reset_seq_pkg::*;
  localparam int PW = 50;
  logic        mclk = 0, rst_n = 0, dsbe = 0, fcm = 0, xtal = 0;
  logic        low = 0, tick = 0, slp = 0, dslp = 0, dsx = 0;
  logic        lowp = 0, pllu = 0, lock = 1;
  logic        cyc = 0, stb = 0, we = 0;
  logic [7:0]  cfg = 8'h00;
  logic [2:0]  osel = 3'h0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] dw = 32'h0, dr, e, lf = 32'he993;
  logic [1:0]  ths;
  logic        ack, srst, run, bde, rc, trap, rearm;
  logic [31:0] q[$];
  int          fail_count = 0, total_checks = 0, cyc_n = 0, traps = 0;

  brownout_reset_sequencer #(.POWER_UP_TIMER_COUNT(PW), .POR_COUNT(4)) dut (
    .mclk(mclk), .rst_n(rst_n), .power_on_config_word(cfg),
    .deep_sleep_bor_enable(dsbe), .initial_osc_select(osel),
    .clock_fail_monitor_en(fcm), .use_crystal(xtal),
    .supply_below_thr_pin(low), .supply_below_por_pin(lowp),
    .osc_tick_pin(tick), .pll_lock_pin(lock), .pll_used(pllu),
    .in_sleep(slp), .in_deep_sleep(dslp), .deep_sleep_exit(dsx),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .system_reset_out(srst), .cpu_run(run),
    .brownout_threshold_select(ths), .bor_detect_enable(bde),
    .fast_internal_rc_osc(rc), .trap_handler(trap), .por_rearm(rearm)
  );
  ////////////////////////////////////////
  // clock and oscillator ticks
  always #20 mclk = ~mclk;
  always @(posedge mclk) tick <= ~tick;

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt

  task automatic close_out;
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  // one classic cycle; reads leave their expectation in the queue
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [15:0] d, input logic [15:0] m);
    if (!w) q.push_back({m, d});
    lf = nxt(lf);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    dw <= w ? {lf[31:16], d} : lf;
    do @(posedge mclk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task automatic pwr_on;
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
  endtask : pwr_on

  // cycles until reset output drops, against the timer setting
  task automatic rel(input logic pt);
    int n;
    n = 0;
    while (srst !== 1'b0 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    check(16'(n >= (pt ? PW : 0) && n < (pt ? 400 : PW)), 16'h1);
  endtask : rel

  // read results against the oldest note
  always @(posedge mclk)
    if (ack === 1'b1 && we === 1'b0) begin
      e = q.pop_front();
      check(dr[15:0] & e[31:16], e[15:0]);
    end

  // cycle ceiling and trap count
  always @(posedge mclk) begin
    cyc_n++;
    if (trap === 1'b1) traps++;
    if (cyc_n == 20000) begin
      fail_count++;
      close_out();
    end
  end
  ////////////////////////////////////////
  initial begin
    logic [15:0] v;
    logic [2:0]  o;
    int          n;
    for (int m = 0; m < 4; m++) begin
      lf = nxt(lf);
      v = lf[15:0];
      o = lf[18:16];
      cfg <= {m[0], lf[20:19], 3'h0, m[1:0]};
      osel <= o;
      pwr_on();
      rel(m[0]);
      bus(0, 4'h0, m == 1 ? 16'h2003 : 16'h0003, 16'hffff);
      bus(0, ADR_OSC, {13'h0, o}, 16'h0007);
      bus(1, 4'h0, 16'h2000, 16'h0);
      bus(0, 4'h0, m == 1 ? 16'h2000 : 16'h0, 16'hffff);
      check(16'(ths), 16'(cfg[6:5]));
      for (int s = 0; s < 2; s++) begin
        slp <= s[0];
        @(posedge mclk);
        @(posedge mclk);
        check(16'(bde), 16'(m == 3 || m == 1 || (m == 2 && s == 0)));
      end
      slp <= 1'b0;
      bus(1, 4'h0, 16'h0, 16'h0);
      check(16'(bde), 16'(m >= 2));
      bus(1, 4'h0, 16'h2000, 16'h0);
      bus(1, ADR_RTCCAL, v, 16'h0);
      bus(1, ADR_NVM, ~v, 16'h0);
      osel <= ~o;
      low <= 1'b1;
      repeat (20) @(posedge mclk);
      check(16'(srst), 16'(m != 0));
      if (m == 3) begin
        low <= 1'b0;
        repeat (20) @(posedge mclk);
        check(16'(srst), 16'h1);
        low <= 1'b1;
        repeat (10) @(posedge mclk);
      end
      low <= 1'b0;
      rel(m[0]);
      bus(0, ADR_RTCCAL, v, 16'hffff);
      bus(0, ADR_NVM, ~v, 16'hffff);
      bus(0, ADR_OSC, {13'h0, m == 0 ? o : ~o}, 16'h0007);
      bus(0, 4'h0, m == 0 ? 16'h0 : 16'h0002, 16'h0003);
    end
    bus(1, 4'h0, 16'h0, 16'h0);
    dsbe <= 1'b1;
    dslp <= 1'b1;
    @(posedge mclk);
    @(posedge mclk);
    check(16'(rearm), 16'h1);
    dsx <= 1'b1;
    @(posedge mclk);
    dsx <= 1'b0;
    dslp <= 1'b0;
    bus(0, 4'h0, 16'h0003, 16'h0003);
    bus(1, 4'h2, 16'hffff, 16'h0);
    bus(0, 4'h2, 16'h0, 16'hffff);
    bus(1, ADR_RTCCAL, v, 16'h0);
    lowp <= 1'b1;
    repeat (4) @(posedge mclk);
    lowp <= 1'b0;
    rel(1'b1);
    bus(0, ADR_RTCCAL, 16'h0, 16'hffff);
    bus(0, 4'h0, 16'h0003, 16'h0003);
    xtal <= 1'b1;
    pwr_on();
    rel(1'b1);
    check(16'(run), 16'h0);
    bus(0, ADR_RTCCAL, 16'h0, 16'hffff);
    n = 0;
    while (run !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    check(16'(n > 1850 && n < 2100), 16'h1);
    pllu <= 1'b1;
    lock <= 1'b0;
    repeat (4) @(posedge mclk);
    check(16'(run), 16'h0);
    lock <= 1'b1;
    repeat (4) @(posedge mclk);
    check(16'(run), 16'h1);
    fcm <= 1'b1;
    pwr_on();
    rel(1'b1);
    repeat (4) @(posedge mclk);
    check(16'(traps), 16'h1);
    check(16'({rc, run}), 16'h3);
    close_out();
  end
endmodule : brownout_reset_sequencer_tb
